// File: dss_pkg.sv
/*
  Constants for the disk status supervisor: status byte bit positions,
  host acknowledge value, error thresholds, interleave and timing counts.
  Assumes a single 125 MHz controller clock.
*/
package dss_pkg;

  // --------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned IDLE_MS = 3000;            // No host activity before park
  localparam int unsigned SETTLE_US = 750_000;       // Rest at park before stepper off
  localparam int unsigned IDLE_CYC = IDLE_MS * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);

  // --------------------------------------------------------------------
  // Host link
  // --------------------------------------------------------------------
  localparam logic [7:0] HOST_ACK = 8'h55;
  localparam logic [1:0] LAST_BYTE = 2'h3;

  // --------------------------------------------------------------------
  // Thresholds and geometry
  // --------------------------------------------------------------------
  localparam logic [9:0] MAX_WR_BYTES = 10'h214;     // 532 bytes per block
  localparam logic [1:0] SEEK_TRIES = 2'h3;
  localparam logic [1:0] HDR_RUN = 2'h3;             // Consecutive headers to confirm
  localparam logic [3:0] TMO_REVS = 4'h9;
  localparam logic [8:0] MAX_RETRIES = 9'h12d;       // 301: more than 300 retries
  localparam logic [7:0] MAX_SPARES = 8'h20;         // 32
  localparam logic [7:0] MAX_BAD = 8'h64;            // 100
  localparam logic [7:0] PARK_TRACK = 8'h9b;         // 155
  localparam logic [3:0] INTERLEAVE = 4'h5;
  localparam logic [3:0] SECT_MASK = 4'hf;           // 16 sectors per track

  // --------------------------------------------------------------------
  // Operating layout bit positions
  // --------------------------------------------------------------------
  localparam int B1_NOACK = 7;
  localparam int B1_ABORT = 6;
  localparam int B1_LOST = 5;
  localparam int B1_SEEK = 4;
  localparam int B1_CRC = 3;
  localparam int B1_TMO = 2;
  localparam int B1_FAIL = 0;
  localparam int B2_SEEK1 = 7;
  localparam int B2_SPOVF = 6;
  localparam int B2_BBOVF = 4;
  localparam int B2_STSEC = 3;
  localparam int B2_SPARED = 2;
  localparam int B2_WRTRK = 1;
  localparam int B3_RESET = 7;
  localparam int B3_BLKINV = 6;

  // --------------------------------------------------------------------
  // Format/debug layout bit positions and compare codes
  // --------------------------------------------------------------------
  localparam int F1_NOIDX = 6;
  localparam int F1_NOSMK = 5;
  localparam int F1_CMP = 0;
  localparam int F2_RESET = 7;
  localparam int F2_TRKINV = 6;
  localparam logic [2:0] CMP_WR_TMO = 3'h0;
  localparam logic [2:0] CMP_RD_TMO = 3'h4;
  localparam logic [2:0] CMP_RD_CRC = 3'h6;
  localparam logic [2:0] CMP_DATA = 3'h7;

endpackage

// File: dss_supervisor.sv
/*
  Disk status supervisor: keeps four status bytes in the format layout and three
  in the operating layout (its fourth byte is sent as zero), returns them to the host at command end, and runs housekeeping
  (power-up scan, seek confirmation, verify after write, retry and spare,
  interleave mapping, head park). Assumes event inputs are one-cycle
  pulses from logic on clk_i; index_i and fmt_mode_i come from pins.
*/
`timescale 1ns/1ns
module dss_supervisor #(
  parameter int unsigned IDLE_CYC = dss_pkg::IDLE_CYC,
  parameter int unsigned SETTLE_CYC = dss_pkg::SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Pins
  input wire logic index_i,
  input wire logic fmt_mode_i,
  // Host command and status link
  input wire logic cmd_start_i,
  input wire logic cmd_write_i,
  input wire logic cmd_no_verify_i,
  input wire logic cmd_done_i,
  input wire logic wr_byte_i,
  output logic cmd_ready_o,
  output logic stat_valid_o,
  output logic [7:0] stat_data_o,
  input wire logic stat_ready_i,
  input wire logic ack_valid_i,
  input wire logic [7:0] ack_data_i,
  // Seek and header events
  input wire logic seek_done_i,
  input wire logic hdr_good_i,
  input wire logic hdr_bad_i,
  input wire logic hdr_wrong_i,
  input wire logic rw_req_i,
  input wire logic search_i,
  output logic reseek_o,
  output logic rw_go_o,
  // Data path events
  input wire logic data_phase_i,
  input wire logic crc_err_i,
  input wire logic rd_ok_i,
  input wire logic wr_done_i,
  input wire logic spare_done_i,
  input wire logic bad_block_i,
  input wire logic data_lost_i,
  input wire logic sptbl_bad_i,
  input wire logic stsec_bad_i,
  input wire logic blk_invalid_i,
  output logic retry_o,
  output logic spare_req_o,
  output logic verify_req_o,
  // Format/debug events
  input wire logic no_index_i,
  input wire logic no_smark_i,
  input wire logic trk_invalid_i,
  input wire logic cmp_wr_tmo_i,
  input wire logic cmp_rd_tmo_i,
  input wire logic cmp_rd_crc_i,
  input wire logic cmp_data_i,
  input wire logic fmt_err_i,
  // Geometry, scan and park
  input wire logic [3:0] log_sector_i,
  output logic [3:0] phys_sector_o,
  input wire logic scan_done_i,
  output logic scan_o,
  input wire logic parked_i,
  output logic park_req_o,
  output logic [7:0] park_track_o,
  output logic stepper_off_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] idx_sync;
  logic [2:0] fmt_sync;
  logic fmt_mode;
  logic index_edge;

  // Three stages; only the second and third are ever compared
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idx_sync <= 3'h0;
      fmt_sync <= 3'h0;
      fmt_mode <= 1'b0;
    end else begin
      idx_sync <= {idx_sync[1:0], index_i};
      fmt_sync <= {fmt_sync[1:0], fmt_mode_i};
      if (fmt_sync[1] == fmt_sync[2]) begin
        fmt_mode <= fmt_sync[2];
      end
    end
  end
  assign index_edge = idx_sync[1] & ~idx_sync[2];

  // ----------------------------------------------------------------------
  // Seek confirmation
  // ----------------------------------------------------------------------
  logic verifying;
  logic track_ok;
  logic pend_rw;
  logic [1:0] tries;
  logic [1:0] run;
  logic seek_fail;
  logic seek_try_fail;
  logic try_fail;

  assign try_fail = verifying & (hdr_bad_i | hdr_wrong_i);
  assign seek_try_fail = try_fail;
  assign seek_fail = try_fail && (tries == dss_pkg::SEEK_TRIES - 2'h1);

  // Each seek is confirmed by three headers in a row; the first two misses reseek, the third fails the seek
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      verifying <= 1'b0;
      track_ok <= 1'b0;
      pend_rw <= 1'b0;
      tries <= 2'h0;
      run <= 2'h0;
      reseek_o <= 1'b0;
      rw_go_o <= 1'b0;
    end else begin
      reseek_o <= 1'b0;
      rw_go_o <= 1'b0;
      if (seek_done_i || (rw_req_i && !track_ok)) begin
        verifying <= 1'b1;
        track_ok <= 1'b0;
        run <= 2'h0;
        if (!verifying) begin
          tries <= 2'h0;
        end
        if (rw_req_i) begin
          pend_rw <= 1'b1;
        end
      end else if (rw_req_i) begin
        rw_go_o <= 1'b1;
      end else if (verifying && hdr_good_i) begin
        run <= run + 2'h1;
        if (run == dss_pkg::HDR_RUN - 2'h1) begin
          verifying <= 1'b0;
          track_ok <= 1'b1;
          rw_go_o <= pend_rw;
          pend_rw <= 1'b0;
        end
      end else if (try_fail) begin
        run <= 2'h0;
        if (seek_fail) begin
          verifying <= 1'b0;
          pend_rw <= 1'b0;
        end else begin
          tries <= tries + 2'h1;
          reseek_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Header search timeout, counted in index pulses
  // ----------------------------------------------------------------------
  logic [3:0] revs;
  logic tmo_hit;

  // Post-seek header reads never time out through this path
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      revs <= 4'h0;
    end else if (!search_i || verifying || tmo_hit) begin
      revs <= 4'h0;
    end else if (index_edge) begin
      revs <= revs + 4'h1;
    end
  end
  assign tmo_hit = search_i && !verifying && (revs == dss_pkg::TMO_REVS);

  // ----------------------------------------------------------------------
  // Write length, verify after write, retry and sparing
  // ----------------------------------------------------------------------
  logic wr_active;
  logic [9:0] wr_cnt;
  logic wr_abort;
  logic [8:0] retries;
  logic crc_hit;
  logic [7:0] spares;
  logic [7:0] bads;

  assign wr_abort = wr_active && wr_byte_i && (wr_cnt == dss_pkg::MAX_WR_BYTES);
  assign crc_hit = crc_err_i && data_phase_i && !verifying;

  // Byte count of the current write; the 533rd byte aborts it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_active <= 1'b0;
      wr_cnt <= 10'h0;
      verify_req_o <= 1'b0;
    end else begin
      verify_req_o <= wr_done_i && wr_active && !cmd_no_verify_i;
      if (cmd_start_i) begin
        wr_active <= cmd_write_i;
        wr_cnt <= 10'h0;
      end else if (wr_abort || wr_done_i) begin
        wr_active <= 1'b0;
      end else if (wr_active && wr_byte_i) begin
        wr_cnt <= wr_cnt + 10'h1;
      end
    end
  end

  // Keep retrying a failing read; when retries run out the sector is bad
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      retries <= 9'h0;
      retry_o <= 1'b0;
      spare_req_o <= 1'b0;
    end else begin
      retry_o <= 1'b0;
      spare_req_o <= 1'b0;
      if (rd_ok_i || cmd_start_i) begin
        retries <= 9'h0;
      end else if (crc_hit) begin
        if (retries == dss_pkg::MAX_RETRIES) begin
          spare_req_o <= 1'b1;
          retries <= 9'h0;
        end else begin
          retry_o <= 1'b1;
          retries <= retries + 9'h1;
        end
      end
    end
  end

  // Spare and bad block tallies saturate rather than wrap
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spares <= 8'h0;
      bads <= 8'h0;
    end else begin
      if (spare_done_i && spares != 8'hff) begin
        spares <= spares + 8'h1;
      end
      if (bad_block_i && bads != 8'hff) begin
        bads <= bads + 8'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status flags: set wins over the clear at command start
  // ----------------------------------------------------------------------
  logic [7:0] op_b1;
  logic [7:0] op_b2;
  logic [7:0] op_b3;
  logic [7:0] fm_b1;
  logic [7:0] fm_b2;
  logic [2:0] fm_code;
  logic [7:0] fm_cnt;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] fset1;
  logic [7:0] fset2;
  logic any_err;
  logic acked;

  always_comb begin
    set1 = 8'h0;
    set1[dss_pkg::B1_ABORT] = wr_abort | sptbl_bad_i;
    set1[dss_pkg::B1_LOST] = data_lost_i;
    set1[dss_pkg::B1_SEEK] = seek_fail;
    set1[dss_pkg::B1_CRC] = crc_hit;
    set1[dss_pkg::B1_TMO] = tmo_hit;
    set2 = 8'h0;
    set2[dss_pkg::B2_SEEK1] = seek_try_fail;
    set2[dss_pkg::B2_WRTRK] = verifying & hdr_wrong_i;
    set2[dss_pkg::B2_SPOVF] = spares > dss_pkg::MAX_SPARES;
    set2[dss_pkg::B2_BBOVF] = bads > dss_pkg::MAX_BAD;
    set2[dss_pkg::B2_STSEC] = stsec_bad_i;
    set2[dss_pkg::B2_SPARED] = spare_done_i;
    fset1 = 8'h0;
    fset1[dss_pkg::F1_NOIDX] = no_index_i;
    fset1[dss_pkg::F1_NOSMK] = no_smark_i;
    fset1[dss_pkg::B1_CRC] = crc_hit;
    fset1[dss_pkg::B1_TMO] = tmo_hit;
    fset1[dss_pkg::F1_CMP] = cmp_data_i;
    fset2 = 8'h0;
    fset2[dss_pkg::F2_TRKINV] = trk_invalid_i;
    fset2[dss_pkg::B2_WRTRK] = verifying & hdr_wrong_i;
    any_err = (|set1) | stsec_bad_i | blk_invalid_i;
  end

  // Error bits restart with each command; persistent bits are kept aside
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_b1 <= 8'h0;
      op_b2 <= 8'h0;
      op_b3 <= 8'h80;
      fm_b1 <= 8'h0;
      fm_b2 <= 8'h80;
    end else begin
      op_b1[6:1] <= (cmd_start_i ? 6'h0 : op_b1[6:1]) | set1[6:1];
      op_b1[dss_pkg::B1_FAIL] <= (op_b1[0] & ~cmd_start_i) | any_err;
      op_b2 <= (cmd_start_i ? 8'h0 : op_b2) | set2;
      op_b3[dss_pkg::B3_BLKINV] <= (op_b3[6] & ~cmd_start_i) | blk_invalid_i;
      fm_b1[6:0] <= (cmd_start_i ? 7'h0 : fm_b1[6:0]) | fset1[6:0];
      fm_b2[6:0] <= (cmd_start_i ? 7'h0 : fm_b2[6:0]) | fset2[6:0];
      // Acknowledge result stands until the next response is answered
      if (ack_valid_i) begin
        op_b1[dss_pkg::B1_NOACK] <= ack_data_i != dss_pkg::HOST_ACK;
        fm_b1[dss_pkg::B1_NOACK] <= ack_data_i != dss_pkg::HOST_ACK;
      end
      // Reset flag is reported once, then dropped after the host answers
      if (acked) begin
        op_b3[dss_pkg::B3_RESET] <= 1'b0;
        fm_b2[dss_pkg::F2_RESET] <= 1'b0;
      end
    end
  end

  // Compare failure cause and format error tally
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fm_code <= dss_pkg::CMP_WR_TMO;
      fm_cnt <= 8'h0;
    end else begin
      if (cmp_data_i) begin
        fm_code <= dss_pkg::CMP_DATA;
      end else if (cmp_rd_crc_i) begin
        fm_code <= dss_pkg::CMP_RD_CRC;
      end else if (cmp_rd_tmo_i) begin
        fm_code <= dss_pkg::CMP_RD_TMO;
      end else if (cmp_wr_tmo_i) begin
        fm_code <= dss_pkg::CMP_WR_TMO;
      end else if (cmd_start_i) begin
        fm_code <= dss_pkg::CMP_WR_TMO;
      end
      // A new error is counted even in the cycle a command starts
      if (fmt_err_i) begin
        fm_cnt <= cmd_start_i ? 8'h1 : (fm_cnt == 8'hff ? fm_cnt : fm_cnt + 8'h1);
      end else if (cmd_start_i) begin
        fm_cnt <= 8'h0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status return to the host
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_ACK = 3'b100
  } dss_link_e;

  dss_link_e link_st;
  logic [1:0] byte_idx;
  logic [7:0] snap [4];

  assign acked = (link_st == ST_ACK) && ack_valid_i;

  // Bytes are frozen at completion so late events cannot change the report being sent
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_st <= ST_IDLE;
      byte_idx <= 2'h0;
      stat_valid_o <= 1'b0;
      stat_data_o <= 8'h0;
      for (int i = 0; i < 4; i++) begin
        snap[i] <= 8'h0;
      end
    end else begin
      unique case (link_st)
        ST_IDLE: begin
          if (cmd_done_i) begin
            snap[0] <= fmt_mode ? fm_b1 : op_b1;
            snap[1] <= fmt_mode ? fm_b2 : op_b2;
            snap[2] <= fmt_mode ? {fm_code, 5'h0} : op_b3;
            snap[3] <= fmt_mode ? fm_cnt : 8'h0;
            stat_data_o <= fmt_mode ? fm_b1 : op_b1;
            stat_valid_o <= 1'b1;
            byte_idx <= 2'h0;
            link_st <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (stat_ready_i) begin
            if (byte_idx == dss_pkg::LAST_BYTE) begin
              stat_valid_o <= 1'b0;
              link_st <= ST_ACK;
            end else begin
              byte_idx <= byte_idx + 2'h1;
              stat_data_o <= snap[byte_idx + 2'h1];
            end
          end
        end
        ST_ACK: begin
          if (ack_valid_i) begin
            link_st <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Power-up scan, interleave and head park
  // ----------------------------------------------------------------------
  logic [31:0] idle_cnt;
  logic [31:0] rest_cnt;
  logic activity;

  assign activity = cmd_start_i | wr_byte_i | ack_valid_i | stat_valid_o;
  assign cmd_ready_o = !scan_o && (link_st == ST_IDLE);
  assign park_track_o = dss_pkg::PARK_TRACK;

  // Host service waits until the surface scan has finished
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_o <= 1'b1;
    end else if (scan_done_i) begin
      scan_o <= 1'b0;
    end
  end

  // Physical slot = logical times five modulo sixteen
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phys_sector_o <= 4'h0;
    end else begin
      phys_sector_o <= 4'((log_sector_i * dss_pkg::INTERLEAVE) & dss_pkg::SECT_MASK);
    end
  end

  // Idle timer parks the heads; resting time then cuts stepper power
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt <= 32'h0;
      rest_cnt <= 32'h0;
      park_req_o <= 1'b0;
      stepper_off_o <= 1'b0;
    end else begin
      park_req_o <= 1'b0;
      if (activity || scan_o) begin
        idle_cnt <= 32'h0;
        stepper_off_o <= 1'b0;
      end else if (idle_cnt < IDLE_CYC) begin
        idle_cnt <= idle_cnt + 32'h1;
        park_req_o <= (idle_cnt == IDLE_CYC - 1);
      end
      if (!parked_i || activity) begin
        rest_cnt <= 32'h0;
      end else if (rest_cnt < SETTLE_CYC) begin
        rest_cnt <= rest_cnt + 32'h1;
        if (rest_cnt == SETTLE_CYC - 1) begin
          stepper_off_o <= 1'b1;
        end
      end
    end
  end

endmodule // dss_supervisor

// File: dss_supervisor_asserts.sv
/*
  Checker for the disk status supervisor: timing relations at its ports.
  Assumes one clock domain and the supervisor's own port names.
*/
`timescale 1ns/1ns
module dss_supervisor_asserts (
  // Watched ports
  input wire logic clk_i, nrst_i, cmd_no_verify_i, wr_done_i, crc_err_i,
  input wire logic data_phase_i, cmd_done_i, stat_ready_i, seek_done_i,
  input wire logic hdr_bad_i, scan_done_i, verify_req_o, retry_o, spare_req_o,
  input wire logic cmd_ready_o, stat_valid_o, reseek_o, scan_o,
  input wire logic [3:0] log_sector_i, phys_sector_o,
  input wire logic [7:0] park_track_o, stat_data_o
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // A data-phase CRC hit, and a first failed header read after a seek
  sequence s_crc; crc_err_i && data_phase_i; endsequence
  sequence s_bad1; seek_done_i ##1 hdr_bad_i; endsequence
  AST_RETRY: assert property (s_crc |=> retry_o || spare_req_o)
    else $error("crc hit gave no retry");
  AST_SEEK_RETRY: assert property (s_bad1 |=> reseek_o)
    else $error("first header failure gave no reseek");
  AST_VERIFY: assert property (wr_done_i |=> verify_req_o == !$past(cmd_no_verify_i))
    else $error("verify request wrong after write");
  AST_PHYS: assert property ($past(nrst_i) |->
    phys_sector_o == 4'($past(log_sector_i) * 4'h5)) else $error("interleave map wrong");
  AST_PARK_TRK: assert property (park_track_o == dss_pkg::PARK_TRACK)
    else $error("park track wrong");
  AST_REPORT: assert property (cmd_done_i && cmd_ready_o |=> stat_valid_o)
    else $error("status report did not start");
  AST_HOLD: assert property (stat_valid_o && !stat_ready_i |=>
    stat_valid_o && $stable(stat_data_o)) else $error("status byte dropped");
  AST_SCAN_END: assert property ($fell(scan_o) |-> $past(scan_done_i))
    else $error("scan ended early");
  AST_SCAN_BUSY: assert property (scan_o |-> !cmd_ready_o)
    else $error("ready during scan");
endmodule // dss_supervisor_asserts

bind dss_supervisor dss_supervisor_asserts u_chk (.*);

// File: dss_host.sv
/*
  Host model: takes the four status bytes and answers each report.
  Assumes the supervisor holds each byte until ready is sampled high.
*/
`timescale 1ns/1ns
module dss_host (
  // Control from the bench
  input wire logic clk_i, nrst_i, stall_i, bad_i,
  // Status link
  input wire logic stat_valid_i,
  input wire logic [7:0] stat_data_i,
  output logic stat_ready_o, ack_valid_o,
  output logic [7:0] ack_data_o,
  // Captured report and report count
  output logic [31:0] rx_o,
  output logic [7:0] cnt_o
);
  logic [1:0] n;
  logic take;
  assign take = stat_valid_i && stat_ready_o;
  // --------------------------------------------------------------------
  // Byte capture and answer
  // --------------------------------------------------------------------
  // Idle answer data toggles so a stale value never looks valid
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {stat_ready_o, ack_valid_o, ack_data_o, rx_o, cnt_o, n} <= '0;
    end else begin
      stat_ready_o <= stall_i ? ~stat_ready_o : 1'b1;
      ack_valid_o <= take && n == 2'h3;
      ack_data_o <= (take && n == 2'h3) ? (bad_i ? 8'haa : 8'h55) : ~ack_data_o;
      if (take) begin
        rx_o <= {rx_o[23:0], stat_data_i};
        n <= n + 2'h1;
        cnt_o <= cnt_o + 8'(n == 2'h3);
      end
    end
  end
endmodule // dss_host

// File: tb.sv
/*
  Self-checking bench for the disk status supervisor with a host model.
  Assumes short idle and settle counts; event inputs are one-cycle pulses.
*/
`timescale 1ns/1ns
module tb;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic clk_i = 0, nrst_i = 0, idx = 0, fmt = 0, nv = 0, srch = 0, dph = 0;
  logic park = 0, stall = 0, bad = 0, pb = 0, b, srdy, ackv, rdy, sv, rs, go;
  logic rt, sp, vr, scan, preq, soff;
  logic [31:0] ev = '0, rx;
  logic [3:0] lsec = '0, psec;
  logic [7:0] cnt, c0, ack_d, sd, ptrk;
  int err_total = 0, tests_run = 0, cyc = 0, nrt = 0, nsp = 0, ngo = 0, npk = 0;
  int n, i, k, r0, s0;
  integer seed = 32'h8fb6;
  `define CK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

  dss_supervisor #(.IDLE_CYC(20), .SETTLE_CYC(10)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
    .index_i(idx), .fmt_mode_i(fmt), .cmd_start_i(ev[0]), .cmd_write_i(1'b1),
    .cmd_no_verify_i(nv), .cmd_done_i(ev[1]), .wr_byte_i(ev[2]), .cmd_ready_o(rdy),
    .stat_valid_o(sv), .stat_data_o(sd), .stat_ready_i(srdy), .ack_valid_i(ackv),
    .ack_data_i(ack_d), .seek_done_i(ev[3]), .hdr_good_i(ev[4]), .hdr_bad_i(ev[5]),
    .hdr_wrong_i(ev[6]), .rw_req_i(ev[7]), .search_i(srch), .reseek_o(rs), .rw_go_o(go),
    .data_phase_i(dph), .crc_err_i(ev[8]), .rd_ok_i(ev[9]), .wr_done_i(ev[10]),
    .spare_done_i(ev[11]), .bad_block_i(ev[12]), .data_lost_i(ev[13]), .sptbl_bad_i(ev[14]),
    .stsec_bad_i(ev[15]), .blk_invalid_i(ev[16]), .retry_o(rt), .spare_req_o(sp),
    .verify_req_o(vr), .no_index_i(ev[17]), .no_smark_i(ev[18]), .trk_invalid_i(ev[19]),
    .cmp_wr_tmo_i(ev[20]), .cmp_rd_tmo_i(ev[21]), .cmp_rd_crc_i(ev[22]), .cmp_data_i(ev[23]),
    .fmt_err_i(ev[24]), .log_sector_i(lsec), .phys_sector_o(psec), .scan_done_i(ev[25]),
    .scan_o(scan), .parked_i(park), .park_req_o(preq), .park_track_o(ptrk),
    .stepper_off_o(soff));
  dss_host u_host (.clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall), .bad_i(bad),
    .stat_valid_i(sv), .stat_data_i(sd), .stat_ready_o(srdy), .ack_valid_o(ackv),
    .ack_data_o(ack_d), .rx_o(rx), .cnt_o(cnt));

  // --------------------------------------------------------------------
  // Clock, monitors and helpers
  // --------------------------------------------------------------------
  initial forever #4 clk_i = ~clk_i;
  // Pulse counters; a timeout guards against a stuck status link
  always @(posedge clk_i) begin
    lsec <= 4'($random(seed));
    {nrt, nsp, ngo, npk} <= {nrt + rt, nsp + sp, ngo + go, npk + preq};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize;
    end
  end
  // Drive one event bit for m cycles; bit 31 is unused and acts as idle
  task automatic p(input int e, input int m);
    repeat (m) @(posedge clk_i) ev <= 32'h1 << e;
  endtask
  // Ask for a report and wait until the host has all four bytes
  task automatic rep(input logic a);
    c0 = cnt;
    p(31, 2);
    @(posedge clk_i) {bad, stall} <= {a, 1'($random(seed))};
    p(1, 1);
    p(31, 1);
    for (n = 0; n < 80 && cnt == c0; n++) @(negedge clk_i);
    `CK(cnt != c0, 1'b1)
    repeat (4) @(posedge clk_i);
  endtask
  function automatic logic [7:0] f_b3(input int c);
    return {(c == 0) ? 3'h0 : (c == 1) ? 3'h4 : (c == 2) ? 3'h6 : 3'h7, 5'h00};
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    `CK(ptrk, 8'h9b)
    `CK(scan, 1'b1)
    p(25, 1);
    p(31, 1);
    @(negedge clk_i);
    `CK({scan, rdy}, 2'b01)
    // Operating layout: block, sector and table errors; answer badly
    p(0, 1); p(16, 1); p(15, 1); p(11, 33); p(12, 101);
    rep(1'b1);
    `CK(rx[30:24], 7'h01)
    `CK((rx[23:16] & 8'h50), 8'h50)
    `CK((rx[23:16] & 8'haf), 8'h0c)
    `CK(rx[15:0], 16'hc000)
    // Oversize write, lost data and header timeout in one command
    p(0, 1); p(2, 533); p(13, 1); p(31, 1);
    @(posedge clk_i) srch <= 1'b1;
    repeat (9) begin
      @(posedge clk_i) idx <= 1'b1;
      repeat (3) @(posedge clk_i);
      idx <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
    srch <= 1'b0;
    rep(1'b0);
    `CK(rx[31], 1'b1)
    `CK(rx[30], 1'b1)
    `CK(rx[29], 1'b1)
    `CK(rx[28:26], 3'h1)
    `CK(rx[25:24], 2'h1)
    `CK(rx[15:8], 8'h00)
    $display("test done: status layout one");
    // Retry run cut by a good read, then a full run ending in a spare
    @(posedge clk_i) dph <= 1'b1;
    r0 = nrt; s0 = nsp;
    p(0, 1); p(8, 150); p(9, 1); p(8, 302); p(31, 3);
    `CK(nrt - r0, 451)
    `CK(nsp - s0, 1)
    dph <= 1'b0;
    repeat (4) begin
      @(posedge clk_i) nv <= 1'($random(seed));
      p(0, 1);
      p(10, 1);
      p(31, 1);
      @(negedge clk_i);
      `CK(vr, ~nv)
    end
    // Access waits for three good headers, then goes once
    r0 = ngo;
    p(7, 1); p(4, 3); p(31, 3);
    `CK(ngo - r0, 1)
    // Two reseeks, then a third failure ends the seek; a CRC hit follows
    p(3, 1); p(5, 1); p(3, 1); p(6, 1); p(3, 1); p(6, 1); p(31, 1);
    dph <= 1'b1;
    p(8, 1); p(31, 1);
    dph <= 1'b0;
    rep(1'b0);
    `CK(rx[31:24], 8'h19)
    `CK(rx[27], 1'b1)
    `CK(rx[23:16], 8'hd2)
    $display("test done: retry, verify and seek");
    // Format layout: every compare code with a random error count
    @(posedge clk_i) fmt <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (i = 0; i < 4; i++) begin
      k = 1 + ($random(seed) & 3);
      b = 1'($random(seed));
      p(0, 1); p(20 + i, 1); p(24, k); p(17, 1); p(19, 1);
      rep(b);
      `CK(rx[31:30], {pb, 1'b1})
      `CK(rx[23:16], 8'h40)
      `CK(rx[15:8], f_b3(i))
      `CK(rx[7:0], 8'(k))
      `CK(rx[24], 1'(i == 3))
      pb = b;
    end
    $display("test done: format layout");
    // Idle park, then stepper power off after the settle time
    @(posedge clk_i) fmt <= 1'b0;
    r0 = npk;
    for (n = 0; n < 80 && npk == r0; n++) @(negedge clk_i);
    `CK(npk > r0, 1'b1)
    @(posedge clk_i) park <= 1'b1;
    repeat (8) @(negedge clk_i);
    `CK(soff, 1'b0)
    repeat (6) @(negedge clk_i);
    `CK(soff, 1'b1)
    $display("test done: park");
    summarize;
  end
endmodule // tb
